// ---- verilog/dsf_pkg.sv ----
/*
  dsf_pkg: constants of the serial frame decoder of a quad 12-bit DAC.
  Assumes: included by every dsf_* design module, used by scoped names only.
*/
`default_nettype none

package dsf_pkg;

  // ----------------------------------------------------------------------
  // command word layout
  // ----------------------------------------------------------------------
  localparam logic [4:0] WORD_BITS  = 5'h18;
  localparam logic [4:0] COUNT_OVER = 5'h19;
  localparam int         RW_BIT     = 23;
  localparam int         SEL_HI     = 21;
  localparam int         SEL_LO     = 19;
  localparam int         ADR_HI     = 18;
  localparam int         ADR_LO     = 16;
  localparam int         DATA_HI    = 15;
  localparam int         CODE_LO    = 4;
  localparam int         CODE_BITS  = 12;
  localparam int         RANGE_BITS = 3;
  localparam int         DATA_BITS  = 16;
  localparam int         FLAG_BITS  = 4;

  // ----------------------------------------------------------------------
  // register select and channel address codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] SEL_DAC    = 3'h0;
  localparam logic [2:0] SEL_RANGE  = 3'h1;
  localparam logic [2:0] SEL_POWER  = 3'h2;
  localparam logic [2:0] SEL_CTRL   = 3'h3;
  localparam logic [2:0] ADR_ALL    = 3'h4;
  localparam logic [2:0] CTRL_FLAGS = 3'h1;
  localparam logic [2:0] CTRL_CLEAR = 3'h4;

  // ----------------------------------------------------------------------
  // output ranges and gains (gain in hundredths)
  // ----------------------------------------------------------------------
  localparam logic [2:0] RANGE_P5   = 3'h0;
  localparam logic [2:0] RANGE_P10  = 3'h1;
  localparam logic [2:0] RANGE_P108 = 3'h2;
  localparam logic [2:0] RANGE_B5   = 3'h3;
  localparam logic [2:0] RANGE_B10  = 3'h4;
  localparam logic [2:0] RANGE_B108 = 3'h5;
  localparam logic [8:0] GAIN_5     = 9'h0C8;
  localparam logic [8:0] GAIN_10    = 9'h190;
  localparam logic [8:0] GAIN_108   = 9'h1B0;
  localparam int         BIP_SHIFT  = 11;
  localparam int         UNI_SHIFT  = 12;

  // ----------------------------------------------------------------------
  // control flags, codes and reset values
  // ----------------------------------------------------------------------
  localparam int          FLAG_SDO_OFF = 0;
  localparam int          FLAG_CLR_SEL = 1;
  localparam logic [11:0] CODE_ZERO    = 12'h000;
  localparam logic [11:0] CODE_MID     = 12'h800;
  localparam logic [15:0] POWER_MASK   = 16'h001F;
  localparam logic [11:0] CODE_RESET   = 12'h000;
  localparam logic [2:0]  RANGE_RESET  = 3'h0;
  localparam logic [15:0] POWER_RESET  = 16'h0000;
  localparam logic [3:0]  CTRL_RESET   = 4'h4;

endpackage : dsf_pkg

`default_nettype wire

// ---- verilog/dsf_serial_port.sv ----
/*
  dsf_serial_port: 24-bit shift port, receive and readback transmit.
  Assumes: serial_clk, frame_sync_n and data are synchronous to mclk
  and each serial_clk level lasts at least one mclk period.
*/
`timescale 1ns/100ps
`default_nettype none

module dsf_serial_port (
  // clock and reset
  input  wire logic                            mclk,
  input  wire logic                            resetn,
  // link pins
  input  wire logic                            serial_clk,
  input  wire logic                            frame_sync_n,
  input  wire logic                            serial_data_in,
  output logic                                 serial_data_out,
  // word side
  input  wire logic [dsf_pkg::WORD_BITS-1:0]   tx_word,
  input  wire logic                            tx_arm,
  output logic      [dsf_pkg::WORD_BITS-1:0]   rx_word,
  output logic                                 rx_valid
);

  typedef enum {link_idle, link_frame} dsf_link_type;

  dsf_link_type              state, next_state;
  logic                      clk_prev, sclk_rise, start, stop;
  logic [4:0]                count, next_count, base;
  logic [23:0]               shift, next_shift;
  logic [23:0]               tx_shift, next_tx_shift;
  logic [23:0]               tx_pend, next_tx_pend;
  logic [23:0]               next_rx_word;
  logic                      next_rx_valid;

  // ----------------------------------------------------------------------
  // framing and shifting
  // ----------------------------------------------------------------------
  always_comb begin
    sclk_rise  = serial_clk && !clk_prev;
    start      = (state == link_idle) && !frame_sync_n;
    stop       = (state == link_frame) && frame_sync_n;
    next_state = start ? link_frame : (stop ? link_idle : state);
    base       = start ? 5'h00 : count;
    next_count = base;
    next_shift = shift;
    next_tx_shift = start ? tx_pend : tx_shift;
    next_tx_pend  = tx_arm ? tx_word : (start ? 24'h000000 : tx_pend);
    if (!frame_sync_n && sclk_rise) begin
      next_shift = {shift[22:0], serial_data_in};
      // saturate so an overlong frame never looks like a whole word
      if (base != dsf_pkg::COUNT_OVER) begin
        next_count = base + 5'h01;
      end
      if (!start) begin
        next_tx_shift = {tx_shift[22:0], 1'b0};
      end
    end
    next_rx_valid = stop && (count == dsf_pkg::WORD_BITS);
    next_rx_word  = next_rx_valid ? shift : rx_word;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state           <= link_idle;
      clk_prev        <= 1'b0;
      count           <= 5'h00;
      shift           <= 24'h000000;
      tx_shift        <= 24'h000000;
      tx_pend         <= 24'h000000;
      rx_word         <= 24'h000000;
      rx_valid        <= 1'b0;
      serial_data_out <= 1'b0;
    end else begin
      state           <= next_state;
      clk_prev        <= serial_clk;
      count           <= next_count;
      shift           <= next_shift;
      tx_shift        <= next_tx_shift;
      tx_pend         <= next_tx_pend;
      rx_word         <= next_rx_word;
      rx_valid        <= next_rx_valid;
      serial_data_out <= next_tx_shift[23];
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  msb_first_in_a : assert property (
    (!frame_sync_n && sclk_rise) |=> shift[0] == $past(serial_data_in))
    else $error("shifted bit is not the sampled data bit");

  whole_word_a : assert property (
    rx_valid |-> $past(count) == dsf_pkg::WORD_BITS && $past(stop))
    else $error("word accepted without exactly 24 bits");

  partial_frame_c : cover property (stop && count != dsf_pkg::WORD_BITS);

endmodule : dsf_serial_port

`default_nettype wire

// ---- verilog/dsf_level_map.sv ----
/*
  dsf_level_map: registered map of one 12-bit code to a signed level.
  Assumes: level is in units of one hundredth of the reference LSB.
*/
`timescale 1ns/100ps
`default_nettype none

module dsf_level_map #(
  parameter int REF_BITS   = 16,
  parameter int LEVEL_BITS = 28
) (
  // clock and reset
  input  wire logic                                mclk,
  input  wire logic                                resetn,
  // code and setup
  input  wire logic [dsf_pkg::CODE_BITS-1:0]       code,
  input  wire logic [dsf_pkg::RANGE_BITS-1:0]      range,
  input  wire logic                                twos,
  input  wire logic [REF_BITS-1:0]                 ref_level,
  // result
  output logic signed [LEVEL_BITS-1:0]             level
);

  logic               bipolar;
  logic [8:0]         gain;
  logic signed [12:0] value;
  logic signed [47:0] prod;
  logic signed [47:0] next_wide;

  always_comb begin
    bipolar = range inside {dsf_pkg::RANGE_B5, dsf_pkg::RANGE_B10,
                            dsf_pkg::RANGE_B108};
    unique case (range)
      dsf_pkg::RANGE_P5,   dsf_pkg::RANGE_B5:   gain = dsf_pkg::GAIN_5;
      dsf_pkg::RANGE_P10,  dsf_pkg::RANGE_B10:  gain = dsf_pkg::GAIN_10;
      dsf_pkg::RANGE_P108, dsf_pkg::RANGE_B108: gain = dsf_pkg::GAIN_108;
      default:                                  gain = 9'h000;
    endcase
    if (!bipolar) begin
      value = $signed({1'b0, code});
    end else if (twos) begin
      value = $signed({code[11], code});
    end else begin
      // offset binary is twos complement with the top bit inverted
      value = $signed({~code[11], ~code[11], code[10:0]});
    end
    prod = 48'(value) * $signed({39'h0, gain}) *
           $signed(48'(ref_level));
    next_wide = bipolar ? (prod >>> dsf_pkg::BIP_SHIFT)
                        : (prod >>> dsf_pkg::UNI_SHIFT);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      level <= '0;
    end else begin
      level <= next_wide[LEVEL_BITS-1:0];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  offset_mid_a : assert property (
    (bipolar && !twos && code == dsf_pkg::CODE_MID) |=> level == 0)
    else $error("offset binary midscale is not zero");

  twos_ends_a : assert property (
    (bipolar && twos && code == dsf_pkg::CODE_MID && ref_level != 0)
    |=> level < 0)
    else $error("twos complement 800 is not negative");

  unipolar_zero_a : assert property (
    (!bipolar && code == dsf_pkg::CODE_ZERO) |=> level == 0)
    else $error("straight binary zero code is not zero");

endmodule : dsf_level_map

`default_nettype wire

// ---- verilog/dsf_frame_decode.sv ----
/*
  dsf_frame_decode: command word decoder and register file of a quad
  12-bit DAC, with per-channel output level mapping.
  Assumes: a host shifts 24-bit words on serial_clk rising edges while
  frame_sync_n is low; all inputs are synchronous to mclk.
*/
// Contract
// - each command word is 24 bits, shifted in most significant first
// - bit 23 read flag, 22 reserved, 21-19 select, 18-16 channel, 15-0 data
// - the read flag chooses reading or writing the addressed register
// - select 000 data, 001 range, 010 power, 011 control register
// - every register can be written and read back
// - the payload is 16 bits in the low word positions
// - offset binary: code 800 is zero, steps of 1/2048 half range
// - twos complement: 000 zero, 7FF most positive, 800 most negative
// - straight binary: zero at code zero, steps of 1/4096 full scale
// - reference gain 2, 4 or 4.32 by range applied to fraction
// - data code sits in bits 15 to 4, low four ignored
// - range field low three bits: +5, +10, +10.8, bipolar 5, 10, 10.8
`timescale 1ns/100ps
`default_nettype none

module dsf_frame_decode #(
  parameter int REF_BITS   = 16,
  parameter int LEVEL_BITS = 28
) (
  // clock and reset
  input  wire logic                                   mclk,
  input  wire logic                                   resetn,
  // serial link
  input  wire logic                                   serial_clk,
  input  wire logic                                   frame_sync_n,
  input  wire logic                                   serial_data_in,
  output logic                                        serial_data_out,
  output logic                                        serial_data_out_en,
  // strap and reference
  input  wire logic                                   coding_select_pin,
  input  wire logic [REF_BITS-1:0]                    reference_input_level,
  // channel state
  output logic [3:0][dsf_pkg::CODE_BITS-1:0]          channel_code,
  output logic [3:0][dsf_pkg::RANGE_BITS-1:0]         channel_range,
  output logic [3:0][LEVEL_BITS-1:0]                  channel_level,
  // device state
  output logic [dsf_pkg::DATA_BITS-1:0]               power_control,
  output logic [dsf_pkg::FLAG_BITS-1:0]               control_flags,
  output logic                                        coding_twos
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [23:0]                               rx_word;
  logic                                      rx_valid;
  logic [23:0]                               tx_word, next_tx_word;
  logic                                      tx_arm, next_tx_arm;
  logic                                      wr, rd;
  logic [2:0]                                sel, adr;
  logic [15:0]                               data, read_data;
  logic [3:0][dsf_pkg::CODE_BITS-1:0]        next_code;
  logic [3:0][dsf_pkg::RANGE_BITS-1:0]       next_range;
  logic [15:0]                               next_power;
  logic [3:0]                                next_flags;
  logic                                      next_sdo_en;
  logic                                      strap_taken;
  logic                                      next_twos;

  // ----------------------------------------------------------------------
  // serial port
  // ----------------------------------------------------------------------
  dsf_serial_port u_port (
    .mclk            (mclk),
    .resetn          (resetn),
    .serial_clk      (serial_clk),
    .frame_sync_n    (frame_sync_n),
    .serial_data_in  (serial_data_in),
    .serial_data_out (serial_data_out),
    .tx_word         (tx_word),
    .tx_arm          (tx_arm),
    .rx_word         (rx_word),
    .rx_valid        (rx_valid)
  );

  // ----------------------------------------------------------------------
  // word fields
  // ----------------------------------------------------------------------
  // the reserved bit is not checked; the host keeps it low
  assign wr   = rx_valid && !rx_word[dsf_pkg::RW_BIT];
  assign rd   = rx_valid && rx_word[dsf_pkg::RW_BIT];
  assign sel  = rx_word[dsf_pkg::SEL_HI:dsf_pkg::SEL_LO];
  assign adr  = rx_word[dsf_pkg::ADR_HI:dsf_pkg::ADR_LO];
  assign data = rx_word[dsf_pkg::DATA_HI:0];

  // ----------------------------------------------------------------------
  // per-channel data and range registers
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : gen_ch
    logic                         hit;
    logic                         bip;
    logic [dsf_pkg::CODE_BITS-1:0] clr_code;

    always_comb begin
      hit = (adr == 3'(g)) || (adr == dsf_pkg::ADR_ALL);
      bip = channel_range[g] >= dsf_pkg::RANGE_B5;
      // clear lands on 0 V or on midscale / negative full scale
      clr_code = ((bip && !coding_twos) ^
                  control_flags[dsf_pkg::FLAG_CLR_SEL]) ?
                 dsf_pkg::CODE_MID : dsf_pkg::CODE_ZERO;
      next_code[g]  = channel_code[g];
      next_range[g] = channel_range[g];
      if (wr && hit && sel == dsf_pkg::SEL_DAC) begin
        next_code[g] = data[dsf_pkg::DATA_HI:dsf_pkg::CODE_LO];
      end else if (wr && sel == dsf_pkg::SEL_CTRL &&
                   adr == dsf_pkg::CTRL_CLEAR) begin
        next_code[g] = clr_code;
      end
      // unknown range codes are refused so the level stays defined
      if (wr && hit && sel == dsf_pkg::SEL_RANGE &&
          data[2:0] <= dsf_pkg::RANGE_B108) begin
        next_range[g] = data[2:0];
      end
    end

    dsf_level_map #(
      .REF_BITS   (REF_BITS),
      .LEVEL_BITS (LEVEL_BITS)
    ) u_map (
      .mclk      (mclk),
      .resetn    (resetn),
      .code      (channel_code[g]),
      .range     (channel_range[g]),
      .twos      (coding_twos),
      .ref_level (reference_input_level),
      .level     (channel_level[g])
    );
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      channel_code  <= {4{dsf_pkg::CODE_RESET}};
      channel_range <= {4{dsf_pkg::RANGE_RESET}};
    end else begin
      channel_code  <= next_code;
      channel_range <= next_range;
    end
  end

  // ----------------------------------------------------------------------
  // power, control, strap and readback
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (sel)
      dsf_pkg::SEL_DAC:
        read_data = adr[2] ? 16'h0000
                  : {channel_code[adr[1:0]], 4'h0};
      dsf_pkg::SEL_RANGE:
        read_data = adr[2] ? 16'h0000
                  : {13'h0000, channel_range[adr[1:0]]};
      dsf_pkg::SEL_POWER:
        read_data = power_control;
      dsf_pkg::SEL_CTRL:
        read_data = {12'h000, control_flags};
      default:
        read_data = 16'h0000;
    endcase
    next_power   = power_control;
    next_flags   = control_flags;
    next_tx_arm  = 1'b0;
    next_tx_word = tx_word;
    if (wr && sel == dsf_pkg::SEL_POWER) begin
      next_power = data & dsf_pkg::POWER_MASK;
    end
    if (wr && sel == dsf_pkg::SEL_CTRL &&
        adr == dsf_pkg::CTRL_FLAGS) begin
      next_flags = data[3:0];
    end
    if (rd) begin
      next_tx_arm  = 1'b1;
      next_tx_word = {rx_word[23:16], read_data};
    end
    next_sdo_en = !next_flags[dsf_pkg::FLAG_SDO_OFF];
    // strap is caught once after reset; a moving pin would reinterpret
    // every code stored on a channel with a bipolar range
    next_twos = strap_taken ? coding_twos : !coding_select_pin;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      power_control      <= dsf_pkg::POWER_RESET;
      control_flags      <= dsf_pkg::CTRL_RESET;
      serial_data_out_en <= ~dsf_pkg::CTRL_RESET[dsf_pkg::FLAG_SDO_OFF];
      tx_arm             <= 1'b0;
      tx_word            <= 24'h000000;
      strap_taken        <= 1'b0;
      coding_twos        <= 1'b0;
    end else begin
      power_control      <= next_power;
      control_flags      <= next_flags;
      serial_data_out_en <= next_sdo_en;
      tx_arm             <= next_tx_arm;
      tx_word            <= next_tx_word;
      strap_taken        <= 1'b1;
      coding_twos        <= next_twos;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  dac_write_a : assert property (
    (wr && sel == dsf_pkg::SEL_DAC && adr == 3'h2)
    |=> channel_code[2] == $past(rx_word[15:4]))
    else $error("channel C code not taken from bits 15 to 4");

  all_channel_write_a : assert property (
    (wr && sel == dsf_pkg::SEL_DAC && adr == dsf_pkg::ADR_ALL)
    |=> channel_code[0] == channel_code[3] &&
        channel_code[1] == channel_code[2] &&
        channel_code[0] == $past(data[15:4]))
    else $error("broadcast write missed a channel");

  range_write_a : assert property (
    (wr && sel == dsf_pkg::SEL_RANGE && adr == 3'h1 && data[2:0] < 3'h6)
    |=> channel_range[1] == $past(data[2:0]))
    else $error("channel B range not written");

  read_keeps_a : assert property (
    rd |=> $stable(channel_code) && $stable(power_control) &&
           $stable(control_flags))
    else $error("a read changed a register");

  readback_word_a : assert property (
    (rd && sel == dsf_pkg::SEL_POWER)
    |=> tx_arm && tx_word[15:0] == $past(power_control) &&
        tx_word[23:16] == $past(rx_word[23:16]))
    else $error("power register readback word wrong");

  power_write_a : assert property (
    (wr && sel == dsf_pkg::SEL_POWER)
    |=> power_control == $past(data & dsf_pkg::POWER_MASK))
    else $error("power register write lost");

  field_split_a : assert property (
    (wr && sel == dsf_pkg::SEL_CTRL && adr == dsf_pkg::CTRL_FLAGS)
    |=> control_flags == $past(rx_word[3:0]) &&
        serial_data_out_en == !$past(rx_word[0]))
    else $error("control flags not taken from low data bits");

  strap_hold_a : assert property (
    strap_taken |=> $stable(coding_twos))
    else $error("coding strap changed after capture");

  range_refuse_a : assert property (
    (wr && sel == dsf_pkg::SEL_RANGE && data[2:0] > dsf_pkg::RANGE_B108)
    |=> $stable(channel_range))
    else $error("a reserved range code was stored");

  word_only_a : assert property (
    !rx_valid |=> $stable(channel_code) && $stable(channel_range) &&
                  $stable(power_control) && $stable(control_flags))
    else $error("a register changed without a whole word");

  clear_code_a : assert property (
    (wr && sel == dsf_pkg::SEL_CTRL && adr == dsf_pkg::CTRL_CLEAR &&
     channel_range[0] < dsf_pkg::RANGE_B5)
    |=> channel_code[0] == (control_flags[dsf_pkg::FLAG_CLR_SEL] ?
                            dsf_pkg::CODE_MID : dsf_pkg::CODE_ZERO))
    else $error("unipolar clear code wrong on channel A");

  dac_readback_a : assert property (
    (rd && sel == dsf_pkg::SEL_DAC && adr == 3'h0)
    |=> tx_word[15:0] == {$past(channel_code[0]), 4'h0})
    else $error("channel A readback word wrong");

  channel_only_a : assert property (
    (wr && sel == dsf_pkg::SEL_DAC && adr == 3'h1)
    |=> $stable(channel_code[0]) && $stable(channel_code[2]) &&
        $stable(channel_code[3]))
    else $error("a single-channel write touched another channel");

  range_only_a : assert property (
    (wr && sel == dsf_pkg::SEL_RANGE)
    |=> $stable(channel_code) && $stable(power_control))
    else $error("a range write touched another register");

  write_no_reply_a : assert property (
    wr |=> !tx_arm)
    else $error("a write armed a readback reply");

  // ----------------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------------
  dac_write_c : cover property (wr && sel == dsf_pkg::SEL_DAC);
  read_c      : cover property (rd ##1 tx_arm);
  clear_c     : cover property (wr && sel == dsf_pkg::SEL_CTRL &&
                                adr == dsf_pkg::CTRL_CLEAR);
  refuse_c    : cover property (wr && sel == dsf_pkg::SEL_RANGE &&
                                data[2:0] > dsf_pkg::RANGE_B108);

endmodule : dsf_frame_decode

`default_nettype wire

// ---- test/dsf_host_model.sv ----
/* dsf_host_model: host serial port that shifts command words, msb first.
   Assumes: the bench calls send; reply bits are sampled before each rise. */
`timescale 1ns/100ps
`default_nettype none
module dsf_host_model (
  // clock
  input  wire logic mclk,
  // link pins
  output logic      serial_clk,
  output logic      frame_sync_n,
  output logic      serial_data_in,
  input  wire logic serial_data_out
);
  initial begin
    serial_clk = 1'b0;
    frame_sync_n = 1'b1;
    serial_data_in = 1'b0;
  end
  task automatic send(input logic [23:0] w, input int nbits,
                      output logic [23:0] rd);
    rd = 24'h000000;
    @(posedge mclk) frame_sync_n <= 1'b0;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < nbits; i++) begin
      serial_data_in <= (i == 1) ? 1'b0 : w[23-i];
      @(posedge mclk);
      @(negedge mclk) rd[23-i] = serial_data_out;
      @(posedge mclk) serial_clk <= 1'b1;
      repeat (2) @(posedge mclk);
      serial_clk <= 1'b0;
    end
    @(posedge mclk) frame_sync_n <= 1'b1;
    // no pull on the data line: show the inverse once released
    serial_data_in <= ~serial_data_in;
    repeat (3) @(posedge mclk);
  endtask : send
endmodule : dsf_host_model
`default_nettype wire

// ---- test/test_dsf_frame_decode.sv ----
/* test_dsf_frame_decode: random word traffic against the frame decoder.
   Assumes: dsf_host_model drives the link pins. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module test_dsf_frame_decode;
  logic             mclk = 1'b0;
  logic             resetn = 1'b0;
  logic             strap = 1'b1;
  logic [15:0]      ref_lvl = 16'h0000;
  wire              sck, fsn, sdi, sdo, sdo_en;
  logic [3:0][11:0] code;
  logic [3:0][2:0]  rng;
  logic [3:0][27:0] lvl;
  logic [15:0]      pwr, d;
  logic [3:0]       flg;
  logic             twos;
  logic [23:0]      rd;
  logic [11:0]      c;
  logic [2:0]       ch, r;
  int               error_cnt = 0, checked = 0, cyc = 0;
  always #20 mclk = ~mclk;
  dsf_host_model host_u (.mclk(mclk), .serial_clk(sck), .frame_sync_n(fsn),
    .serial_data_in(sdi), .serial_data_out(sdo));
  dsf_frame_decode dut_u (.mclk(mclk), .resetn(resetn), .serial_clk(sck),
    .frame_sync_n(fsn), .serial_data_in(sdi), .serial_data_out(sdo),
    .serial_data_out_en(sdo_en), .coding_select_pin(strap),
    .reference_input_level(ref_lvl), .channel_code(code),
    .channel_range(rng), .channel_level(lvl), .power_control(pwr),
    .control_flags(flg), .coding_twos(twos));
  function automatic logic [27:0] exp_lvl(logic [11:0] c, logic [2:0] r,
                                          logic [15:0] rf, logic tw);
    longint v, g;
    g = (r % 3 == 0) ? dsf_pkg::GAIN_5 : (r % 3 == 1) ? dsf_pkg::GAIN_10
      : dsf_pkg::GAIN_108;
    v = (r < 3) ? longint'(c) : tw ? longint'(signed'(c))
      : longint'(c) - 2048;
    v = rf * g * v;
    return (r > 2) ? 28'(v >>> 11) : 28'(v >>> 12);
  endfunction : exp_lvl
  task automatic wr(input logic [2:0] sel, input logic [2:0] a,
                    input logic [15:0] dd, input int n = 24);
    host_u.send({2'b00, sel, a, dd}, n, rd);
    repeat (3) @(posedge mclk);
  endtask : wr
  task automatic results;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // ----------------------------------------------------------------------
  // hang guard
  // ----------------------------------------------------------------------
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      results();
    end
  end
  // write a range and a code, then compare stored state and level
  task automatic chan(input logic tw);
    ch = 3'($urandom_range(4));
    c = 12'($urandom);
    r = 3'($urandom_range(5));
    ref_lvl <= 16'($urandom_range(4095));
    wr(dsf_pkg::SEL_RANGE, ch, {13'h0000, r});
    wr(dsf_pkg::SEL_DAC, ch, {c, 4'($urandom)});
    for (int k = 0; k < 4; k++) begin
      if (ch == 3'h4 || ch == 3'(k)) begin
        `CHK(code[k], c)
        `CHK(rng[k], r)
        `CHK(lvl[k], exp_lvl(c, r, ref_lvl, tw))
      end
    end
  endtask : chan
  // broadcast a range, try a reserved one, set flags, clear all codes
  task automatic clr(input logic tw);
    r = 3'($urandom_range(5));
    d = 16'($urandom);
    wr(dsf_pkg::SEL_RANGE, 3'h4, {13'h0000, r});
    wr(dsf_pkg::SEL_RANGE, 3'h4, {13'h0000, 2'h3, d[8]});
    wr(dsf_pkg::SEL_CTRL, 3'h1, d);
    `CHK(flg, d[3:0])
    `CHK(sdo_en, !d[0])
    wr(dsf_pkg::SEL_CTRL, 3'h4, 16'h0000);
    c = ((r > 3'h2 && !tw) ^ d[1]) ? dsf_pkg::CODE_MID : dsf_pkg::CODE_ZERO;
    for (int k = 0; k < 4; k++) begin
      `CHK(rng[k], r)
      `CHK(code[k], c)
    end
  endtask : clr
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(98));
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK(flg, dsf_pkg::CTRL_RESET)
    `CHK(twos, 1'b0)
    repeat (40) begin
      chan(1'b0);
      if (ch != 3'h4) begin
        wr(dsf_pkg::SEL_DAC, ch, {~c, 4'h0});
        rd[23] = 1'b1;
        host_u.send({1'b1, 1'b0, dsf_pkg::SEL_DAC, ch, 16'h0000}, 24, rd);
        wr(dsf_pkg::SEL_CTRL, 3'h0, 16'h0000);
        `CHK(rd, {2'b10, dsf_pkg::SEL_DAC, ch, ~c, 4'h0})
      end
      d = 16'($urandom);
      wr(dsf_pkg::SEL_POWER, 3'h0, d);
      `CHK(pwr, d & dsf_pkg::POWER_MASK)
      host_u.send({1'b1, 1'b0, dsf_pkg::SEL_POWER, 3'h0, 16'h0000}, 24, rd);
      wr(dsf_pkg::SEL_CTRL, 3'h0, 16'h0000);
      d = d & dsf_pkg::POWER_MASK;
      `CHK(rd, {2'b10, dsf_pkg::SEL_POWER, 3'h0, d})
      c = 12'($urandom);
      wr(dsf_pkg::SEL_DAC, 3'h0, {c, 4'h0});
      wr(dsf_pkg::SEL_DAC, 3'h0, ~{c, 4'h0}, 23);
      `CHK(code[0], c)
      clr(1'b0);
    end
    strap <= 1'b0;
    resetn <= 1'b0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK(twos, 1'b1)
    repeat (20) begin
      chan(1'b1);
      clr(1'b1);
    end
    results();
  end
endmodule : test_dsf_frame_decode
`default_nettype wire
